/* File: src/irq_pkg.sv */
package irq_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam logic [7:0] FORCED_CALL_OP = 8'hBB;
    localparam int VEC_IND_BIT = 7;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 13'h0000;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_CALL,
        OP_RET,
        OP_RET_EN
    } flow_op_t;
    typedef enum logic [1:0] {
        PSU_NONE,
        PSU_SET,
        PSU_CLEAR,
        PSU_LOAD
    } psu_op_t;
endpackage : irq_pkg

/* File: src/irq_link_if.sv */
`timescale 1ns/10ps
interface irq_link_if;
    logic interrupt_request_n;
    logic interrupt_acknowledge;
    logic operation_request;
    logic operation_acknowledge_n;
    logic [7:0] data_bus_from_dev;
    logic [7:0] data_bus_from_per;
    logic data_bus_per_oe;
    logic [7:0] data_bus_pins;
    assign data_bus_pins = data_bus_per_oe ? data_bus_from_per : data_bus_from_dev;
    modport device (
        input interrupt_request_n,
        output interrupt_acknowledge,
        output operation_request,
        input operation_acknowledge_n,
        output data_bus_from_dev,
        input data_bus_pins
    );
    modport peripheral (
        output interrupt_request_n,
        input interrupt_acknowledge,
        input operation_request,
        output operation_acknowledge_n,
        output data_bus_from_per,
        output data_bus_per_oe
    );
endinterface : irq_link_if

/* File: src/irq_peripheral.sv */
`timescale 1ns/10ps
module irq_peripheral (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_raise,
    input wire logic [7:0] i_vector,
    output logic o_busy,
    irq_link_if.peripheral link
);
    logic ack_s1_q;
    logic ack_s2_q;
    logic req_s1_q;
    logic req_s2_q;
    logic pending_q;
    logic operation_acknowledge_n_n_q;
    logic oe_q;
    logic [7:0] vec_q;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= link.interrupt_acknowledge;
            ack_s2_q <= ack_s1_q;
            req_s1_q <= link.operation_request;
            req_s2_q <= req_s1_q;
        end
    end

    // Request held until acknowledge phase
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pending_q <= 1'b0;
            vec_q <= 8'h00;
        end else if (i_raise && !pending_q) begin
            pending_q <= 1'b1;
            vec_q <= i_vector;
        end else if (ack_s2_q) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            oe_q <= 1'b0;
            operation_acknowledge_n_n_q <= 1'b1;
        end else begin
            oe_q <= ack_s2_q && req_s2_q;
            operation_acknowledge_n_n_q <= !(ack_s2_q && req_s2_q && oe_q);
        end
    end

    assign link.interrupt_request_n = !pending_q;
    assign link.operation_acknowledge_n = operation_acknowledge_n_n_q;
    assign link.data_bus_from_per = vec_q;
    assign link.data_bus_per_oe = oe_q;
    assign o_busy = pending_q;
endmodule : irq_peripheral

/* File: src/irq_unit.sv */
`timescale 1ns/10ps
// Summary of operation
// - One request input, vectored by 8 bits
// - Accepting request sets inhibit bit
// - Inhibit set blocks interrupt service
// - Upper status load/preset can set inhibit
// - Reset, clear/load, return-enable clear inhibit
// - Service only after current instruction
// - Final cycle jams forced call opcode
// - Next cycle fetches vector under acknowledge
// - Peripheral drives vector, acknowledges operation
// - Request held until acknowledge returns
// - Second cycle executes call, fetches target
// - Low seven bits signed from zero
// - Vector bit 7 selects indirect
// - Zero vector calls address zero
// - Forced call pushes return address
// - Return stack holds eight entries
// - Call: advance, increment, store, load target
// - Return: load from stack, decrement
// - Memory-mapped peripherals decode like memory
// - Interrupt acknowledge and operation request are active high; interrupt request and operation acknowledge are active low
// - Controls valid only during request
// - Request at reset release gets serviced
module irq_unit #(
    parameter int ADDR_W = irq_pkg::ADDR_W,
    parameter int DEPTH = irq_pkg::STACK_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_last_cycle,
    input wire logic [ADDR_W-1:0] i_next_addr,
    input wire irq_pkg::flow_op_t i_flow_op,
    input wire logic [ADDR_W-1:0] i_call_target,
    input wire irq_pkg::psu_op_t i_psu_op,
    input wire logic i_psu_inhibit,
    input wire logic i_indirect_done,
    input wire logic [ADDR_W-1:0] i_indirect_addr,
    output logic o_inhibit,
    output logic o_forced_op_valid,
    output logic [7:0] o_instruction_register,
    output logic o_jump_valid,
    output logic [ADDR_W-1:0] o_jump_addr,
    output logic o_indirect_req,
    output logic [ADDR_W-1:0] o_indirect_ptr,
    output logic [irq_pkg::SP_W-1:0] o_stack_ptr,
    irq_link_if.device link
);
    typedef enum logic [2:0] {
        S_RUN,
        S_VEC_FETCH,
        S_VEC_DONE,
        S_CALL,
        S_INDIRECT
    } state_t;

    state_t state_q;
    logic req_s1_q;
    logic req_s2_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic inhibit_q;
    logic operation_request_q;
    logic interrupt_acknowledge_q;
    logic [7:0] vector_q;
    logic [7:0] ir_q;
    logic forced_q;
    logic jump_q;
    logic [ADDR_W-1:0] jump_addr_q;
    logic ind_req_q;
    logic [ADDR_W-1:0] ind_ptr_q;
    logic [ADDR_W-1:0] ret_addr_q;
    logic [irq_pkg::SP_W-1:0] sp_q;
    logic [ADDR_W-1:0] ras_q [DEPTH];
    logic take_irq;
    logic do_push;
    logic [ADDR_W-1:0] push_addr;
    logic [irq_pkg::SP_W-1:0] sp_inc;
    logic [ADDR_W-1:0] vec_target;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            req_s1_q <= !link.interrupt_request_n;
            req_s2_q <= req_s1_q;
            ack_s1_q <= !link.operation_acknowledge_n;
            ack_s2_q <= ack_s1_q;
        end
    end

    // pending request after reset taken at first boundary
    assign take_irq = (state_q == S_RUN) && i_last_cycle && req_s2_q && !inhibit_q;

    // signed seven-bit offset from zero, wraps
    assign vec_target = ADDR_W'($signed(vector_q[6:0]));
    assign sp_inc = sp_q + 3'(1);
    // forced call pushes like ordinary call
    assign do_push = (state_q == S_CALL) || (state_q == S_RUN && i_flow_op == irq_pkg::OP_CALL);
    assign push_addr = (state_q == S_CALL) ? ret_addr_q : i_next_addr;

    // set on accept; program set; clears
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            inhibit_q <= 1'b0;
        end else if (take_irq) begin
            inhibit_q <= 1'b1;
        end else if (i_psu_op == irq_pkg::PSU_SET && i_psu_inhibit) begin
            inhibit_q <= 1'b1;
        end else if (i_psu_op == irq_pkg::PSU_CLEAR && i_psu_inhibit) begin
            inhibit_q <= 1'b0;
        end else if (i_psu_op == irq_pkg::PSU_LOAD) begin
            inhibit_q <= i_psu_inhibit;
        end else if (state_q == S_RUN && i_flow_op == irq_pkg::OP_RET_EN) begin
            inhibit_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sp_q <= '0;
        end else if (do_push) begin
            sp_q <= sp_inc;
        end else if (state_q == S_RUN && i_flow_op inside {irq_pkg::OP_RET, irq_pkg::OP_RET_EN}) begin
            sp_q <= sp_q - 3'(1);
        end
    end

    generate
        for (genvar g = 0; g < DEPTH; g++) begin : g_ras
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    ras_q[g] <= '0;
                end else if (do_push && sp_inc == 3'(g)) begin
                    ras_q[g] <= push_addr;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= S_RUN;
            operation_request_q <= 1'b0;
            interrupt_acknowledge_q <= 1'b0;
            vector_q <= 8'h00;
            ir_q <= 8'h00;
            forced_q <= 1'b0;
            jump_q <= 1'b0;
            jump_addr_q <= '0;
            ind_req_q <= 1'b0;
            ind_ptr_q <= '0;
            ret_addr_q <= '0;
        end else begin
            forced_q <= 1'b0;
            jump_q <= 1'b0;
            case (state_q)
                S_RUN: begin
                    if (take_irq) begin
                        ir_q <= irq_pkg::FORCED_CALL_OP;
                        forced_q <= 1'b1;
                        ret_addr_q <= i_next_addr;
                        operation_request_q <= 1'b1;
                        interrupt_acknowledge_q <= 1'b1;
                        state_q <= S_VEC_FETCH;
                    end else if (i_flow_op == irq_pkg::OP_CALL) begin
                        jump_q <= 1'b1;
                        jump_addr_q <= i_call_target;
                    end else if (i_flow_op inside {irq_pkg::OP_RET, irq_pkg::OP_RET_EN}) begin
                        jump_q <= 1'b1;
                        jump_addr_q <= ras_q[sp_q];
                    end
                end
                S_VEC_FETCH: begin
                    if (ack_s2_q) begin
                        vector_q <= link.data_bus_pins;
                        operation_request_q <= 1'b0;
                        state_q <= S_VEC_DONE;
                    end
                end
                S_VEC_DONE: begin
                    if (!ack_s2_q) begin
                        interrupt_acknowledge_q <= 1'b0;
                        state_q <= S_CALL;
                    end
                end
                S_CALL: begin
                    if (vector_q[irq_pkg::VEC_IND_BIT]) begin
                        ind_req_q <= 1'b1;
                        ind_ptr_q <= vec_target;
                        state_q <= S_INDIRECT;
                    end else begin
                        jump_q <= 1'b1;
                        jump_addr_q <= vec_target;
                        state_q <= S_RUN;
                    end
                end
                S_INDIRECT: begin
                    if (i_indirect_done) begin
                        ind_req_q <= 1'b0;
                        jump_q <= 1'b1;
                        jump_addr_q <= i_indirect_addr;
                        state_q <= S_RUN;
                    end
                end
                default: begin
                    state_q <= S_RUN;
                end
            endcase
        end
    end

    assign link.interrupt_acknowledge = interrupt_acknowledge_q;
    assign link.operation_request = operation_request_q;
    assign link.data_bus_from_dev = 8'h00;
    assign o_inhibit = inhibit_q;
    assign o_forced_op_valid = forced_q;
    assign o_instruction_register = ir_q;
    assign o_jump_valid = jump_q;
    assign o_jump_addr = jump_addr_q;
    assign o_indirect_req = ind_req_q;
    assign o_indirect_ptr = ind_ptr_q;
    assign o_stack_ptr = sp_q;
endmodule : irq_unit

/* File: bench/irq_link_assertions.sv */
`timescale 1ns/10ps
module irq_link_assertions (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic interrupt_acknowledge,
    input wire logic operation_request,
    input wire logic operation_acknowledge_n,
    input wire logic [7:0] data_bus_pins,
    input wire logic data_bus_per_oe
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    a_req_holds_open: assert property (
        operation_request && operation_acknowledge_n |=> operation_request)
        else $error("request dropped before acknowledge");
    a_ack_drops_req: assert property (
        $fell(operation_acknowledge_n) |-> ##[1:6] !operation_request)
        else $error("request not released after acknowledge");
    a_ack_needs_req: assert property (
        $fell(operation_acknowledge_n) |-> operation_request)
        else $error("acknowledge without request");
    a_ack_released: assert property (
        $fell(operation_request) |-> ##[1:6] operation_acknowledge_n)
        else $error("acknowledge not withdrawn");
    a_req_has_interrupt_acknowledge: assert property (
        operation_request |-> interrupt_acknowledge)
        else $error("vector fetch without interrupt acknowledge");
    a_interrupt_acknowledge_outlasts: assert property (
        interrupt_acknowledge && !operation_acknowledge_n |=> interrupt_acknowledge)
        else $error("interrupt acknowledge dropped early");
    a_interrupt_acknowledge_ends: assert property (
        $rose(operation_acknowledge_n) |-> ##[1:6] !interrupt_acknowledge)
        else $error("interrupt acknowledge stuck");
    a_vector_driven: assert property (
        !operation_acknowledge_n |-> data_bus_per_oe)
        else $error("acknowledge with bus not driven");
    a_vector_steady: assert property (
        !operation_acknowledge_n && !$past(operation_acknowledge_n) |-> $stable(data_bus_pins))
        else $error("vector changed during acknowledge");
endmodule : irq_link_assertions

/* File: bench/vectored_interrupt_and_return_stack_test.sv */
`timescale 1ns/10ps
module vectored_interrupt_and_return_stack_test;
    logic i_clk, i_rstn, i_last_cycle, i_psu_inhibit, i_indirect_done, i_raise;
    logic [12:0] i_next_addr, i_call_target, i_indirect_addr;
    irq_pkg::flow_op_t i_flow_op;
    irq_pkg::psu_op_t i_psu_op;
    logic [7:0] i_vector, o_instruction_register;
    logic o_inhibit, o_forced_op_valid, o_jump_valid, o_indirect_req, o_busy;
    logic [12:0] o_jump_addr, o_indirect_ptr;
    logic [2:0] o_stack_ptr;
    logic [12:0] stk [8];
    logic [2:0] sp;
    int err_count, total_checks, cycles;
    irq_link_if link ();
    irq_unit irq_unit_inst (.i_clk, .i_rstn, .i_last_cycle, .i_next_addr, .i_flow_op, .i_call_target,
        .i_psu_op, .i_psu_inhibit, .i_indirect_done, .i_indirect_addr, .o_inhibit, .o_forced_op_valid,
        .o_instruction_register, .o_jump_valid, .o_jump_addr, .o_indirect_req, .o_indirect_ptr,
        .o_stack_ptr, .link(link.device));
    irq_peripheral irq_peripheral_inst (.i_clk, .i_rstn, .i_raise, .i_vector, .o_busy,
        .link(link.peripheral));
    irq_link_assertions irq_link_assertions_inst (.i_clk, .i_rstn,
        .interrupt_acknowledge(link.interrupt_acknowledge), .operation_request(link.operation_request),
        .operation_acknowledge_n(link.operation_acknowledge_n), .data_bus_pins(link.data_bus_pins),
        .data_bus_per_oe(link.data_bus_per_oe));

    always #4 i_clk = ~i_clk;

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            close_out();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One final cycle carrying a flow and status operation
    task automatic step(input irq_pkg::flow_op_t op, input logic [12:0] tgt, input logic [12:0] nxt,
        input irq_pkg::psu_op_t psu, input logic inh);
        @(negedge i_clk);
        i_last_cycle = 1'b1;
        i_flow_op = op;
        i_call_target = tgt;
        i_next_addr = nxt;
        i_psu_op = psu;
        i_psu_inhibit = inh;
        @(negedge i_clk);
        i_last_cycle = 1'b0;
        i_flow_op = irq_pkg::OP_NONE;
        i_psu_op = irq_pkg::PSU_NONE;
    endtask : step

    task automatic wait_jump(input logic [12:0] exp);
        int n;
        n = 0;
        while (o_jump_valid !== 1'b1 && n < 60) begin
            @(negedge i_clk);
            n++;
        end
        check(o_jump_valid, 1'b1);
        check(o_jump_addr, exp);
        check(o_stack_ptr, sp);
    endtask : wait_jump

    task automatic call(input logic [12:0] tgt, input logic [12:0] nxt);
        step(irq_pkg::OP_CALL, tgt, nxt, irq_pkg::PSU_NONE, 1'b0);
        sp++;
        stk[sp] = nxt;
        wait_jump(tgt);
    endtask : call

    task automatic ret(input logic en);
        logic [12:0] exp;
        step(en ? irq_pkg::OP_RET_EN : irq_pkg::OP_RET, 13'h0000, 13'h0000, irq_pkg::PSU_NONE, 1'b0);
        exp = stk[sp];
        sp--;
        if (en) check(o_inhibit, 1'b0);
        wait_jump(exp);
    endtask : ret

    task automatic irq(input logic rs, input logic [7:0] v, input logic [12:0] nxt, input logic [12:0] ind,
        input logic take);
        int n;
        if (rs) begin
            i_raise = 1'b1;
            i_vector = v;
            @(negedge i_clk);
            i_raise = 1'b0;
            check(o_busy, 1'b1);
        end else begin
            @(negedge i_clk);
        end
        i_last_cycle = 1'b1;
        i_next_addr = nxt;
        n = 0;
        while (o_forced_op_valid !== 1'b1 && n < 24) begin
            @(negedge i_clk);
            n++;
        end
        i_last_cycle = 1'b0;
        check(o_forced_op_valid, take);
        check(o_busy, 1'b1);
        if (!take) return;
        check(o_instruction_register, irq_pkg::FORCED_CALL_OP);
        check(o_inhibit, 1'b1);
        sp++;
        stk[sp] = nxt;
        if (v[7]) begin
            n = 0;
            while (o_indirect_req !== 1'b1 && n < 60) begin
                @(negedge i_clk);
                n++;
            end
            check(o_indirect_req, 1'b1);
            check(o_indirect_ptr, {{6{v[6]}}, v[6:0]});
            i_indirect_addr = ind;
            i_indirect_done = 1'b1;
            @(negedge i_clk);
            i_indirect_done = 1'b0;
            wait_jump(ind);
        end else begin
            wait_jump({{6{v[6]}}, v[6:0]});
        end
        check(o_busy, 1'b0);
    endtask : irq

    initial begin
        logic [7:0] vecs [4];
        vecs = '{8'h00, 8'h3F, 8'h40, 8'h7F};
        {i_clk, i_rstn, i_last_cycle, i_psu_inhibit, i_indirect_done, i_raise} = 6'h00;
        {i_next_addr, i_call_target, i_indirect_addr, i_vector, sp} = 50'h0;
        i_flow_op = irq_pkg::OP_NONE;
        i_psu_op = irq_pkg::PSU_NONE;
        {err_count, total_checks, cycles} = 96'h0;
        repeat (12) @(negedge i_clk);
        i_rstn = 1'b1;
        check(o_inhibit, 1'b0);
        check(link.operation_request, 1'b0);
        // Vector displacement extremes and zero vector
        foreach (vecs[k]) begin
            irq(1'b1, vecs[k], 13'h0100 + 13'(k), 13'h0000, 1'b1);
            ret(1'b1);
        end
        irq(1'b1, 8'h85, 13'h0ABC, 13'h1234, 1'b1);
        ret(1'b1);
        $display("vector tests done");
        step(irq_pkg::OP_NONE, 13'h0000, 13'h0000, irq_pkg::PSU_SET, 1'b1);
        check(o_inhibit, 1'b1);
        irq(1'b1, 8'h22, 13'h0200, 13'h0000, 1'b0);
        check(link.interrupt_acknowledge, 1'b0);
        step(irq_pkg::OP_NONE, 13'h0000, 13'h0000, irq_pkg::PSU_CLEAR, 1'b1);
        check(o_inhibit, 1'b0);
        irq(1'b0, 8'h22, 13'h0200, 13'h0000, 1'b1);
        ret(1'b0);
        check(o_inhibit, 1'b1);
        step(irq_pkg::OP_NONE, 13'h0000, 13'h0000, irq_pkg::PSU_LOAD, 1'b0);
        check(o_inhibit, 1'b0);
        step(irq_pkg::OP_NONE, 13'h0000, 13'h0000, irq_pkg::PSU_LOAD, 1'b1);
        check(o_inhibit, 1'b1);
        $display("inhibit tests done");
        // Nine nested calls wrap the pointer
        for (int i = 1; i <= 9; i++) call(13'h0400 + 13'(i), 13'(16 * i));
        for (int i = 0; i < 8; i++) ret(1'b0);
        $display("stack tests done");
        close_out();
    end
endmodule : vectored_interrupt_and_return_stack_test
